// ===== design/acr_params.svh
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// Register word indices; the byte address is four times the index
`define ACR_IDX_ROUTE 8'h3b
`define ACR_IDX_CONV 8'h3c
`define ACR_IDX_TEMP 8'h3d

// Reset values
`define ACR_RST_ROUTE 8'h00
`define ACR_RST_CONV 8'hc0
`define ACR_RST_TEMP 8'h00

// Writable masks (reserved read-only bits excluded)
`define ACR_WMASK_ROUTE 8'hdf
`define ACR_WMASK_CONV 8'hcf
`define ACR_WMASK_TEMP 8'h0f

// Field positions
`define ACR_B_TRIM 7
`define ACR_B_CFGERR 6
`define ACR_B_HEART 4
`define ACR_B_ACT 3
`define ACR_B_INACT 2
`define ACR_B_DBL 1
`define ACR_B_SGL 0
`define ACR_B_FMT_HI 7
`define ACR_B_FMT_LO 6
`define ACR_B_EN 0

// Format codes
`define ACR_FMT_LEGACY 2'h0
`define ACR_FMT_8 2'h1
`define ACR_FMT_12 2'h2
`define ACR_FMT_FULL 2'h3

`endif

// ===== design/acr_pkg.sv
package acr_pkg;
  // Upper-group event sources toward the second pin
  typedef struct packed {
    logic trim_error;
    logic config_error;
    logic heartbeat_timer;
    logic aux_activity;
    logic aux_inactivity;
    logic double_knock;
    logic single_knock;
  } acr_events_t;

  // Stored queue entry: channel id and 14-bit sample
  typedef struct packed {
    logic [1:0] chan;
    logic [13:0] data;
  } acr_entry_t;

  // Enables to the conversion engines
  typedef struct packed {
    logic ext_conv_on;
    logic ext_conv_activity_on;
    logic ext_conv_inactivity_on;
    logic thermal_on;
    logic thermal_activity_on;
    logic thermal_inactivity_on;
  } acr_enables_t;
endpackage

// ===== design/acr_regs.sv
`timescale 1ns/100ps
`include "acr_params.svh"
module acr_regs
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Event sources, same clock domain
  input wire acr_events_t events_in,
  // Queue read-out path
  input wire acr_entry_t entry_in,
  input wire logic entry_valid,
  output logic [15:0] entry_out,
  output logic entry_out_valid,
  // Engine enables and pin
  output acr_enables_t enables,
  output logic second_irq_pin
);

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  logic [7:0] route_reg;
  logic [7:0] conv_reg;
  logic [7:0] temp_reg;
  logic ack_reg;
  logic access;
  logic wr_take;
  logic rd_take;

  // One wait cycle per access keeps read data straight from a flop
  assign access = (avs_read | avs_write) & ~ack_reg;
  assign wr_take = avs_write & ack_reg;
  assign rd_take = avs_read & ~ack_reg;

  // Handshake: waitrequest high until the acknowledge cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= access;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~access;
  end

  // Register writes; reserved read-only bits masked off
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      route_reg <= `ACR_RST_ROUTE;
      conv_reg <= `ACR_RST_CONV;
      temp_reg <= `ACR_RST_TEMP;
    end
    else if (wr_take && avs_byteenable[0])
    begin
      if (avs_address == {`ACR_IDX_ROUTE} << 2)
        route_reg <= avs_writedata[7:0] & `ACR_WMASK_ROUTE;
      if (avs_address == {`ACR_IDX_CONV} << 2)
        conv_reg <= avs_writedata[7:0] & `ACR_WMASK_CONV;
      if (avs_address == {`ACR_IDX_TEMP} << 2)
        temp_reg <= avs_writedata[7:0] & `ACR_WMASK_TEMP;
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      avs_readdata <= 32'h0;
    else if (rd_take)
    begin
      if (avs_address == {`ACR_IDX_ROUTE} << 2)
        avs_readdata <= {24'h0, route_reg};
      else if (avs_address == {`ACR_IDX_CONV} << 2)
        avs_readdata <= {24'h0, conv_reg};
      else if (avs_address == {`ACR_IDX_TEMP} << 2)
        avs_readdata <= {24'h0, temp_reg};
      else
        avs_readdata <= 32'h0;
    end
  end

  //--------------------------------------------------------------
  // Interrupt routing
  //--------------------------------------------------------------
  logic irq_next;
  // Heartbeat bit read as steering the second pin, despite the text
  always_comb
  begin
    irq_next = (events_in.trim_error & route_reg[`ACR_B_TRIM])
      | (events_in.config_error & route_reg[`ACR_B_CFGERR])
      | (events_in.heartbeat_timer & route_reg[`ACR_B_HEART])
      | (events_in.aux_activity & route_reg[`ACR_B_ACT])
      | (events_in.aux_inactivity & route_reg[`ACR_B_INACT])
      | (events_in.double_knock & route_reg[`ACR_B_DBL])
      | (events_in.single_knock & route_reg[`ACR_B_SGL]);
  end

  // Registered pin, one cycle behind the source
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      second_irq_pin <= 1'b0;
    else
      second_irq_pin <= irq_next;
  end

  //--------------------------------------------------------------
  // Engine enables
  //--------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      enables <= '0;
    else
    begin
      enables.ext_conv_on <= conv_reg[`ACR_B_EN] & ~temp_reg[`ACR_B_EN];
      enables.ext_conv_activity_on <= conv_reg[`ACR_B_ACT - 2];
      enables.ext_conv_inactivity_on <= conv_reg[`ACR_B_ACT];
      enables.thermal_on <= temp_reg[`ACR_B_EN];
      enables.thermal_activity_on <= temp_reg[`ACR_B_ACT - 2];
      enables.thermal_inactivity_on <= temp_reg[`ACR_B_ACT];
    end
  end

  //--------------------------------------------------------------
  // Queue read-out formatting
  //--------------------------------------------------------------
  logic [15:0] fmt_next;
  // Entry is kept at 14 bits; only presentation varies
  always_comb
  begin
    unique case (conv_reg[`ACR_B_FMT_HI:`ACR_B_FMT_LO])
      `ACR_FMT_LEGACY: fmt_next = {entry_in.chan, 2'h0, entry_in.data[13:2]};
      `ACR_FMT_8: fmt_next = {8'h0, entry_in.data[13:6]};
      `ACR_FMT_12: fmt_next = {4'h0, entry_in.data[13:2]};
      `ACR_FMT_FULL: fmt_next = {entry_in.chan, entry_in.data};
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      entry_out <= 16'h0;
      entry_out_valid <= 1'b0;
    end
    else
    begin
      entry_out <= fmt_next;
      entry_out_valid <= entry_valid;
    end
  end

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  a_route_reset: assert property (@(posedge clk_sys) $rose(reset_n) |-> route_reg == 8'h00)
    else $error("route register not zero after reset");
  a_conv_reset: assert property (@(posedge clk_sys) $rose(reset_n) |-> conv_reg == 8'hc0)
    else $error("converter control not c0 after reset");
  a_route_rsvd: assert property (@(posedge clk_sys) disable iff (!reset_n) route_reg[5] == 1'b0)
    else $error("route reserved bit set");
  a_temp_rsvd: assert property (@(posedge clk_sys) disable iff (!reset_n) temp_reg[7:4] == 4'h0)
    else $error("temperature reserved bits set");
  a_pin_knock: assert property (@(posedge clk_sys) disable iff (!reset_n)
    events_in.single_knock && route_reg[0] |=> second_irq_pin)
    else $error("routed single knock missed");
  a_pin_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (irq_next == 1'b0) |=> !second_irq_pin)
    else $error("pin active with no routed source");
  a_trim_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
    route_reg == 8'h80 && !events_in.trim_error |=> !second_irq_pin)
    else $error("pin active without trim error");
  a_ext_blocked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    temp_reg[0] |=> !enables.ext_conv_on)
    else $error("external converter on with temperature");
  a_fmt_eight: assert property (@(posedge clk_sys) disable iff (!reset_n)
    conv_reg[7:6] == 2'h1 |=> entry_out[15:8] == 8'h0)
    else $error("8-bit format upper byte not zero");
  a_wait_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles");
  //--------------------------------------------------------------
  // Rule checks
  //--------------------------------------------------------------

  // Each routed source reaches the pin one cycle later
  a_trim_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
    events_in.trim_error && route_reg[7] |=> second_irq_pin)
    else $error("routed trim error missed");
  a_cfg_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
    events_in.config_error && route_reg[6] |=> second_irq_pin)
    else $error("routed config error missed");
  a_heart_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
    events_in.heartbeat_timer && route_reg[4] |=> second_irq_pin)
    else $error("routed heartbeat missed");
  a_act_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
    events_in.aux_activity && route_reg[3] |=> second_irq_pin)
    else $error("routed activity missed");
  a_inact_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
    events_in.aux_inactivity && route_reg[2] |=> second_irq_pin)
    else $error("routed inactivity missed");
  a_dbl_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
    events_in.double_knock && route_reg[1] |=> second_irq_pin)
    else $error("routed double knock missed");

  // A lone route bit must not let other sources through
  a_cfg_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
    route_reg == 8'h40 && !events_in.config_error |=> !second_irq_pin)
    else $error("pin active without config error");
  a_heart_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
    route_reg == 8'h10 && !events_in.heartbeat_timer |=> !second_irq_pin)
    else $error("pin active without heartbeat");
  a_act_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
    route_reg == 8'h08 && !events_in.aux_activity |=> !second_irq_pin)
    else $error("pin active without activity");
  a_inact_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
    route_reg == 8'h04 && !events_in.aux_inactivity |=> !second_irq_pin)
    else $error("pin active without inactivity");
  a_dbl_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
    route_reg == 8'h02 && !events_in.double_knock |=> !second_irq_pin)
    else $error("pin active without double knock");
  a_sgl_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
    route_reg == 8'h01 && !events_in.single_knock |=> !second_irq_pin)
    else $error("pin active without single knock");

  // Engine enables follow the register bits one cycle later
  a_ext_on: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> enables.ext_conv_on == $past(conv_reg[0] & ~temp_reg[0]))
    else $error("external converter enable wrong");
  a_ext_act: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> enables.ext_conv_activity_on == $past(conv_reg[1]))
    else $error("external activity enable wrong");
  a_ext_inact: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> enables.ext_conv_inactivity_on == $past(conv_reg[3]))
    else $error("external inactivity enable wrong");
  a_therm_on: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> enables.thermal_on == $past(temp_reg[0]))
    else $error("thermal enable wrong");
  a_therm_act: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> enables.thermal_activity_on == $past(temp_reg[1]))
    else $error("thermal activity enable wrong");
  a_therm_inact: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> enables.thermal_inactivity_on == $past(temp_reg[3]))
    else $error("thermal inactivity enable wrong");

  // Read-out shape per format code
  a_fmt_full: assert property (@(posedge clk_sys) disable iff (!reset_n)
    entry_valid && conv_reg[7:6] == 2'h3 |=> entry_out == $past(entry_in))
    else $error("full format entry wrong");
  a_fmt_legacy: assert property (@(posedge clk_sys) disable iff (!reset_n)
    entry_valid && conv_reg[7:6] == 2'h0 |=> entry_out == {$past(entry_in.chan), 2'h0, $past(entry_in.data[13:2])})
    else $error("legacy format entry wrong");
  a_fmt_twelve: assert property (@(posedge clk_sys) disable iff (!reset_n)
    entry_valid && conv_reg[7:6] == 2'h2 |=> entry_out == {4'h0, $past(entry_in.data[13:2])})
    else $error("12-bit format entry wrong");
  a_fmt_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    entry_valid && conv_reg[7:6] == 2'h1 |=> entry_out[7:0] == $past(entry_in.data[13:6]))
    else $error("8-bit format entry wrong");
  a_valid_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> entry_out_valid == $past(entry_valid))
    else $error("entry valid not one cycle behind");

  // Register access and reset values
  a_conv_rsvd: assert property (@(posedge clk_sys) disable iff (!reset_n) conv_reg[5:4] == 2'h0)
    else $error("converter reserved bits set");
  a_temp_reset: assert property (@(posedge clk_sys) $rose(reset_n) |-> temp_reg == 8'h00)
    else $error("temperature control not zero after reset");
  a_pin_reset: assert property (@(posedge clk_sys) $rose(reset_n) |-> !second_irq_pin)
    else $error("pin active after reset");
  a_enables_reset: assert property (@(posedge clk_sys) $rose(reset_n) |-> enables == '0)
    else $error("enables set after reset");
  a_route_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_take && avs_byteenable[0] && avs_address == 8'hec |=> route_reg == ($past(avs_writedata[7:0]) & `ACR_WMASK_ROUTE))
    else $error("route write did not land");
  a_conv_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_take && avs_byteenable[0] && avs_address == 8'hf0 |=> conv_reg == ($past(avs_writedata[7:0]) & `ACR_WMASK_CONV))
    else $error("converter write did not land");
  a_temp_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_take && avs_byteenable[0] && avs_address == 8'hf4 |=> temp_reg == ($past(avs_writedata[7:0]) & `ACR_WMASK_TEMP))
    else $error("temperature write did not land");
  a_lane_refuse: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_take && !avs_byteenable[0] |=> $stable(route_reg) && $stable(conv_reg) && $stable(temp_reg))
    else $error("write without lane zero landed");
  a_read_upper: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd_take |=> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_read_unmapped: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd_take && avs_address != 8'hec && avs_address != 8'hf0 && avs_address != 8'hf4 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_wait_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(avs_read) |=> !avs_waitrequest)
    else $error("read not answered next cycle");

  c_trim: cover property (@(posedge clk_sys) events_in.trim_error && route_reg[7]);
  c_write: cover property (@(posedge clk_sys) wr_take);
  c_read: cover property (@(posedge clk_sys) rd_take);
  c_pin: cover property (@(posedge clk_sys) $rose(second_irq_pin));
  c_full: cover property (@(posedge clk_sys) entry_out_valid && conv_reg[7:6] == 2'h3);

endmodule

// ===== tb/acr_host_model.sv
`timescale 1ns/100ps
module acr_host_model
  import acr_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Source levels asked for by the bench
  input wire acr_events_t ev_cmd,
  output acr_events_t events_in,
  // Pin as the host sees it
  input wire logic second_irq_pin,
  output logic irq_seen
);
  // Sources move just after the edge, like core logic would
  always @(posedge clk_sys)
  begin
    events_in <= ev_cmd;
    irq_seen <= second_irq_pin;
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import acr_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_sys = 0, reset_n = 0, avs_read = 0, avs_write = 0, entry_valid = 0;
  logic avs_waitrequest, entry_out_valid, second_irq_pin, irq_seen;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf;
  logic [15:0] entry_out;
  acr_events_t events_in, ev_cmd = '0;
  acr_entry_t entry_in = '0, ent;
  acr_enables_t enables;
  logic [31:0] qr[$], qe[$];
  int fails = 0, compares = 0, cyc = 0, seed = 32'h76bdca80, b, f, j;

  always #20 clk_sys = ~clk_sys;

  acr_regs u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .events_in(events_in),
    .entry_in(entry_in), .entry_valid(entry_valid), .entry_out(entry_out),
    .entry_out_valid(entry_out_valid), .enables(enables), .second_irq_pin(second_irq_pin));
  acr_host_model u_host (.clk_sys(clk_sys), .ev_cmd(ev_cmd), .events_in(events_in),
    .second_irq_pin(second_irq_pin), .irq_seen(irq_seen));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Request held until waitrequest is seen low; one idle edge after
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    qr.push_back({24'h0, e});
    acc(1'b0, a, 8'h00);
  endtask

  // Registered outputs are looked at mid-cycle, away from the edge
  task look(input int n, input logic [31:0] seen_sel, input logic [31:0] e);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(seen_sel ? {31'h0, irq_seen} : {26'h0, enables}, e);
    @(posedge clk_sys);
  endtask

  function automatic logic [15:0] shape(input logic [1:0] m, input acr_entry_t x);
    case (m)
      2'h0: return {x.chan, 2'b00, x.data[13:2]};
      2'h1: return {8'h00, x.data[13:6]};
      2'h2: return {4'h0, x.data[13:2]};
      default: return {x.chan, x.data};
    endcase
  endfunction

  // Oldest note is matched against every answer as it appears
  always @(posedge clk_sys)
  begin
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, qr.pop_front());
    if (entry_out_valid === 1'b1) chk({16'h0, entry_out}, qe.pop_front());
  end

  // Cuts a hang short; the run needs well under 2000 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      close_out;
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(8'hec, 8'h00);
    rd(8'hf0, 8'hc0);
    rd(8'hf4, 8'h00);
    rd(8'he8, 8'h00);
    $display("test reset values done");
    avs_byteenable <= 4'he;
    acc(1'b1, 8'hf4, 8'h0f);
    avs_byteenable <= 4'hf;
    rd(8'hf4, 8'h00);
    acc(1'b1, 8'hec, 8'hff);
    acc(1'b1, 8'hf0, 8'hff);
    acc(1'b1, 8'hf4, 8'hff);
    acc(1'b1, 8'he8, 8'hff);
    rd(8'hec, 8'hdf);
    rd(8'hf0, 8'hcf);
    rd(8'hf4, 8'h0f);
    rd(8'he8, 8'h00);
    look(0, 0, 32'h1f);
    acc(1'b1, 8'hf4, 8'h0a);
    look(0, 0, 32'h3b);
    acc(1'b1, 8'hf0, 8'h00);
    look(0, 0, 32'h03);
    acc(1'b1, 8'hf0, 8'h0b);
    acc(1'b1, 8'hf4, 8'h05);
    look(0, 0, 32'h1c);
    $display("test access and enables done");
    // Back-to-back entries in every read-out format
    for (f = 0; f < 4; f++)
    begin
      acc(1'b1, 8'hf0, {f[1:0], 6'h00});
      for (j = 0; j < 3; j++)
      begin
        ent = 16'($random(seed));
        entry_in <= ent;
        entry_valid <= 1'b1;
        qe.push_back({16'h0, shape(f[1:0], ent)});
        @(posedge clk_sys);
      end
      entry_valid <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    $display("test formats done");
    // One route bit at a time; other sources random
    for (b = 0; b < 7; b++)
    begin
      acc(1'b1, 8'hec, 8'h01 << ((b >= 5) ? b + 1 : b));
      ev_cmd <= 7'($random(seed)) | (7'h01 << b);
      look(4, 1, 32'h1);
      ev_cmd <= 7'($random(seed)) & ~(7'h01 << b);
      look(4, 1, 32'h0);
    end
    acc(1'b1, 8'hec, 8'h00);
    ev_cmd <= 7'h7f;
    look(4, 1, 32'h0);
    $display("test routing done");
    close_out;
  end
endmodule
